// [shared/sd_decimator_defs.vh]
// Constants for the sigma-delta decimator and sample coding block
// Function
// - Six independent channels, each with own gain, modulator and filter, one clock.
// - Each modulator bit stream arrives at device master clock over eight.
// - Filter decimates from clock/8 to clock/256, one bit to fifteen bits.
// - Filter is sinc cubed: cube of a 32-tap boxcar.
// - Sample words are two's complement; negative inputs set the top bit, or bit 14 in mixed mode.
// - Data mode sends the 15-bit result shifted left with a zero LSB.
// - At or above positive full scale the word saturates to 0x7fff, or to 0x3fff in mixed mode.
// - Mixed mode keeps 15 bits; the top bit of every sample word is held at zero.
// - Three-bit gain codes 0..7 select 0,6,12,18,20,26,32,38 dB.
// - Reference is 1.25 V, 2.5 V when reference control bit 7 is set.
// - Buffered reference pin enabled only while reference control bit 6 is set.
// - Serial words shift at the serial clock rate, MSB first.
// - Device is serial master; the host never starts a transfer.
// - Device master clock comes from the external clock by a programmable divider.
// - Data mode when mode bit 0 is set; mixed mode also needs bit 1.
`ifndef SD_DECIMATOR_DEFS_VH
`define SD_DECIMATOR_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SERIAL_MODE   8'h00
`define OFS_CLOCK_DIV     8'h04
`define OFS_REF_CONTROL   8'h08
`define OFS_GAIN_FIRST    8'h0c
`define OFS_GAIN_SECOND   8'h10
`define OFS_GAIN_THIRD    8'h14
`define OFS_STATUS        8'h18
`define OFS_SAMPLE_BASE   8'h20
`define OFS_SAMPLE_LAST   8'h34

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BIT_DATA_MODE     0
`define BIT_MIXED_MODE    1
`define BIT_REF_OUT_EN    6
`define BIT_REF_HIGH      7
`define BIT_OVERRUN       8
`define RST_CTRL          8'h00

// ----------------------------------------
// Counts, limits, saturation words and response codes
// ----------------------------------------
`define MOD_DIV_LAST      3'h7
`define DECIM_LAST        5'h1f
`define DIV_CODE_MAX      3'h4
`define WORD_BITS_LAST    4'hf
`define SAT_WORD          16'h7fff
`define SAT_WORD_MIXED    16'h3fff
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [verilog/sd_decimator.v]
// Six-channel sinc-cubed decimator, sample coding, sample FIFO and serial master
`timescale 1ns/10ps
`include "sd_decimator_defs.vh"

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_push;
  wire            do_pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign level     = count_reg;
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// Decimator top
// ----------------------------------------
module sd_decimator (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [5:0]  modulator_bits,
  output wire [17:0] channel_gain_select,
  output wire        ref_high_range_enable,
  output wire        ref_output_enable,
  output wire        serial_clock,
  output wire        serial_frame,
  output wire        serial_data,
  output wire        serial_data_oe
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_FRAME = 3'b010;
  localparam ST_SHIFT = 3'b100;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Scale the 18-bit sinc-cubed sum (range +/-32768) to 15 bits and code it
  function [15:0] format_word;
    input [17:0] sum;
    input        mixed;
    reg   [16:0] half;
    reg          sat;
    begin
      half = sum[17:1];
      sat  = ~half[16] & (half[15] | half[14]);
      if (mixed) begin
        format_word = sat ? `SAT_WORD_MIXED : {1'b0, half[14:0]};
      end else begin
        format_word = sat ? `SAT_WORD : {half[14:0], 1'b0};
      end
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  serial_mode_reg;
  reg  [2:0]  clock_div_reg;
  reg  [7:0]  ref_control_reg;
  reg  [7:0]  gain_reg_first;
  reg  [7:0]  gain_reg_second;
  reg  [7:0]  gain_reg_third;
  reg         overrun_reg;
  wire        wr_take;
  wire        rd_take;
  wire [7:0]  wr_ofs;
  wire [7:0]  rd_ofs;
  wire        clear_overrun;
  wire        set_overrun;
  wire        data_mode;
  wire        mixed_mode;

  assign data_mode  = serial_mode_reg[`BIT_DATA_MODE];
  assign mixed_mode = data_mode & serial_mode_reg[`BIT_MIXED_MODE];

  // Both channels must be present: a lone address or data waits
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_take       = s_axi_awready;
  assign wr_ofs        = s_axi_awaddr[7:0];
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take       = s_axi_arvalid & s_axi_arready;
  assign rd_ofs        = s_axi_araddr[7:0];
  assign clear_overrun = wr_take & (wr_ofs == `OFS_STATUS) & s_axi_wstrb[1] & s_axi_wdata[`BIT_OVERRUN];

  function wr_mapped;
    input [7:0] ofs;
    begin
      wr_mapped = (ofs == `OFS_SERIAL_MODE) | (ofs == `OFS_CLOCK_DIV) | (ofs == `OFS_REF_CONTROL) |
                  (ofs == `OFS_GAIN_FIRST) | (ofs == `OFS_GAIN_SECOND) | (ofs == `OFS_GAIN_THIRD) |
                  (ofs == `OFS_STATUS);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_mode_reg <= `RST_CTRL;
      clock_div_reg   <= 3'h0;
      ref_control_reg <= `RST_CTRL;
      gain_reg_first  <= `RST_CTRL;
      gain_reg_second <= `RST_CTRL;
      gain_reg_third  <= `RST_CTRL;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `RESP_OKAY;
    end else begin
      if (wr_take && s_axi_wstrb[0]) begin
        case (wr_ofs)
          `OFS_SERIAL_MODE: serial_mode_reg <= s_axi_wdata[7:0];
          `OFS_CLOCK_DIV:   clock_div_reg   <= s_axi_wdata[2:0];
          `OFS_REF_CONTROL: ref_control_reg <= s_axi_wdata[7:0];
          `OFS_GAIN_FIRST:  gain_reg_first  <= s_axi_wdata[7:0];
          `OFS_GAIN_SECOND: gain_reg_second <= s_axi_wdata[7:0];
          `OFS_GAIN_THIRD:  gain_reg_third  <= s_axi_wdata[7:0];
          default: ;
        endcase
      end
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped(wr_ofs) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Two channels per gain register: low nibble even, high nibble odd
  assign channel_gain_select = {gain_reg_third[6:4], gain_reg_third[2:0],
                                gain_reg_second[6:4], gain_reg_second[2:0],
                                gain_reg_first[6:4], gain_reg_first[2:0]};
  assign ref_high_range_enable = ref_control_reg[`BIT_REF_HIGH];
  assign ref_output_enable     = ref_control_reg[`BIT_REF_OUT_EN];

  // ----------------------------------------
  // Clock division
  // ----------------------------------------
  reg  [2:0] div_cnt_reg;
  reg  [2:0] mod_cnt_reg;
  reg  [4:0] decim_cnt_reg;
  wire [2:0] div_last;
  wire       dm_tick;
  wire       mod_tick;
  wire       decim_strobe;

  // Codes above the largest divide by five rather than wrap
  assign div_last     = (clock_div_reg > `DIV_CODE_MAX) ? `DIV_CODE_MAX : clock_div_reg;
  assign dm_tick      = (div_cnt_reg >= div_last);
  assign mod_tick     = dm_tick & (mod_cnt_reg == `MOD_DIV_LAST);
  assign decim_strobe = mod_tick & (decim_cnt_reg == `DECIM_LAST);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg   <= 3'h0;
      mod_cnt_reg   <= 3'h0;
      decim_cnt_reg <= 5'h00;
    end else begin
      div_cnt_reg <= dm_tick ? 3'h0 : div_cnt_reg + 3'h1;
      if (dm_tick) begin
        mod_cnt_reg <= mod_cnt_reg + 3'h1;
      end
      if (mod_tick) begin
        decim_cnt_reg <= decim_cnt_reg + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [5:0] mod_s1_reg;
  reg [5:0] mod_s2_reg;
  reg [5:0] mod_s3_reg;
  reg [5:0] mod_bit_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      mod_s1_reg  <= 6'h00;
      mod_s2_reg  <= 6'h00;
      mod_s3_reg  <= 6'h00;
      mod_bit_reg <= 6'h00;
    end else begin
      mod_s1_reg <= modulator_bits;
      mod_s2_reg <= mod_s1_reg;
      mod_s3_reg <= mod_s2_reg;
      mod_bit_reg <= (mod_bit_reg & ~(mod_s2_reg ^ mod_s3_reg) ^ mod_bit_reg) |
                     (mod_s2_reg & ~(mod_s2_reg ^ mod_s3_reg)) |
                     (mod_bit_reg & (mod_s2_reg ^ mod_s3_reg));
    end
  end

  // ----------------------------------------
  // Sinc-cubed filters
  // ----------------------------------------
  // Modular arithmetic: integrator wrap cancels in the combs
  reg  [17:0] integ1_reg [0:5];
  reg  [17:0] integ2_reg [0:5];
  reg  [17:0] integ3_reg [0:5];
  reg  [17:0] comb1_reg  [0:5];
  reg  [17:0] comb2_reg  [0:5];
  reg  [17:0] comb3_reg  [0:5];
  reg  [15:0] word_reg   [0:5];
  integer     ch;

  always @(posedge aclk) begin
    for (ch = 0; ch < 6; ch = ch + 1) begin
      if (!aresetn) begin
        integ1_reg[ch] <= 18'h00000;
        integ2_reg[ch] <= 18'h00000;
        integ3_reg[ch] <= 18'h00000;
        comb1_reg[ch]  <= 18'h00000;
        comb2_reg[ch]  <= 18'h00000;
        comb3_reg[ch]  <= 18'h00000;
        word_reg[ch]   <= 16'h0000;
      end else if (mod_tick) begin
        integ1_reg[ch] <= integ1_reg[ch] + (mod_bit_reg[ch] ? 18'h00001 : 18'h3ffff);
        integ2_reg[ch] <= integ2_reg[ch] + integ1_reg[ch];
        integ3_reg[ch] <= integ3_reg[ch] + integ2_reg[ch];
        if (decim_strobe) begin
          comb1_reg[ch] <= integ3_reg[ch];
          comb2_reg[ch] <= integ3_reg[ch] - comb1_reg[ch];
          comb3_reg[ch] <= integ3_reg[ch] - comb1_reg[ch] - comb2_reg[ch];
          word_reg[ch]  <= format_word(integ3_reg[ch] - comb1_reg[ch] - comb2_reg[ch] - comb3_reg[ch],
                                       mixed_mode);
        end
      end
    end
  end

  // ----------------------------------------
  // Channel sequencer into the FIFO
  // ----------------------------------------
  reg         seq_active_reg;
  reg  [2:0]  seq_ch_reg;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_pop;
  wire [15:0] fifo_out_data;
  wire [2:0]  fifo_level;
  wire        push;

  assign push        = seq_active_reg & fifo_in_ready;
  // A new strobe while words are still waiting loses the old set
  assign set_overrun = decim_strobe & seq_active_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      seq_active_reg <= 1'b0;
      seq_ch_reg     <= 3'h0;
      overrun_reg    <= 1'b0;
    end else begin
      overrun_reg <= set_overrun | (overrun_reg & ~clear_overrun);
      if (decim_strobe) begin
        seq_active_reg <= 1'b1;
        seq_ch_reg     <= 3'h0;
      end else if (push) begin
        seq_active_reg <= (seq_ch_reg != 3'h5);
        seq_ch_reg     <= seq_ch_reg + 3'h1;
      end
    end
  end

  sample_fifo #(
    .WIDTH (16),
    .DEPTH (4),
    .AW    (2)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (seq_active_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (word_reg[seq_ch_reg]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // ----------------------------------------
  // Serial master
  // ----------------------------------------
  reg  [2:0]  tx_state_reg;
  reg         sclk_reg;
  reg         frame_reg;
  reg         oe_reg;
  reg  [15:0] shift_reg;
  reg  [3:0]  bit_cnt_reg;
  wire        bit_tick;

  assign bit_tick       = dm_tick & sclk_reg;
  // The device alone starts a transfer; nothing from the host is awaited
  assign fifo_pop       = (tx_state_reg == ST_IDLE) & bit_tick & data_mode & fifo_out_valid;
  assign serial_clock   = sclk_reg;
  assign serial_frame   = frame_reg;
  assign serial_data    = shift_reg[15];
  assign serial_data_oe = oe_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= ST_IDLE;
      sclk_reg     <= 1'b0;
      frame_reg    <= 1'b0;
      oe_reg       <= 1'b0;
      shift_reg    <= 16'h0000;
      bit_cnt_reg  <= 4'h0;
    end else begin
      if (dm_tick) begin
        sclk_reg <= ~sclk_reg;
      end
      case (tx_state_reg)
        ST_IDLE: begin
          if (fifo_pop) begin
            shift_reg    <= fifo_out_data;
            frame_reg    <= 1'b1;
            tx_state_reg <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (bit_tick) begin
            frame_reg    <= 1'b0;
            oe_reg       <= 1'b1;
            bit_cnt_reg  <= `WORD_BITS_LAST;
            tx_state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (bit_tick) begin
            if (bit_cnt_reg == 4'h0) begin
              oe_reg       <= 1'b0;
              tx_state_reg <= ST_IDLE;
            end else begin
              shift_reg   <= {shift_reg[14:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg - 4'h1;
            end
          end
        end
        default: tx_state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  wire [2:0] rd_idx;

  assign rd_idx = rd_ofs[4:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      case (rd_ofs)
        `OFS_SERIAL_MODE: s_axi_rdata <= {24'h000000, serial_mode_reg};
        `OFS_CLOCK_DIV:   s_axi_rdata <= {29'h00000000, clock_div_reg};
        `OFS_REF_CONTROL: s_axi_rdata <= {24'h000000, ref_control_reg};
        `OFS_GAIN_FIRST:  s_axi_rdata <= {24'h000000, gain_reg_first};
        `OFS_GAIN_SECOND: s_axi_rdata <= {24'h000000, gain_reg_second};
        `OFS_GAIN_THIRD:  s_axi_rdata <= {24'h000000, gain_reg_third};
        `OFS_STATUS:      s_axi_rdata <= {23'h000000, overrun_reg, 1'b0, tx_state_reg, 1'b0, fifo_level};
        default: begin
          if (rd_ofs >= `OFS_SAMPLE_BASE && rd_ofs <= `OFS_SAMPLE_LAST && rd_ofs[1:0] == 2'h0) begin
            s_axi_rdata <= {16'h0000, word_reg[rd_idx]};
          end else begin
            s_axi_rresp <= `RESP_SLVERR;
          end
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [verif/host_rx_model.sv]
// Host-side receiver model for the device-driven serial link
`timescale 1ns/10ps
module host_rx_model (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        serial_clock,
  input  wire        serial_frame,
  input  wire        serial_data,
  input  wire        serial_data_oe,
  output reg  [15:0] word,
  output reg         word_valid,
  output reg         first_of_group
);
  // One device on the chain, well inside the limit
  parameter MAX_CHAIN = 8;
  reg        sclk_q;
  reg [15:0] shift;
  integer    left;
  integer    idle;
  // ----------------------------------------
  // Listen only: the host never starts a word
  // ----------------------------------------
  always @(posedge aclk) begin
    sclk_q <= serial_clock;
    word_valid <= 1'b0;
    idle = idle + 1;
    if (!aresetn) begin
      left = 0;
      idle = 0;
    end else if (sclk_q && !serial_clock) begin
      // Sample one clock after serial_clock falls, MSB first
      if (serial_frame) begin
        left = 16;
        first_of_group <= (idle > 60);
        idle = 0;
      end else if (left > 0 && serial_data_oe) begin
        shift = {shift[14:0], serial_data};
        left = left - 1;
        if (left == 0) begin
          word <= shift;
          word_valid <= 1'b1;
        end
      end
    end
  end
endmodule

// [verif/sd_decimator_assertions.sv]
// Port-level checks for the decimator top
`timescale 1ns/10ps
module sd_decimator_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        serial_clock,
  input wire        serial_frame,
  input wire        serial_data,
  input wire        serial_data_oe
);
  reg       sclk_q;
  reg [4:0] oe_cnt;
  // Bit periods seen while the data line is driven
  always @(posedge aclk) begin
    sclk_q <= serial_clock;
    if (!aresetn || !serial_data_oe)
      oe_cnt <= 5'h0;
    else if (serial_clock && !sclk_q)
      oe_cnt <= oe_cnt + 5'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  frame_lead_a: assert property ($fell(serial_frame) |-> serial_data_oe)
    else $error("frame not followed by data");
  bit_steady_a: assert property (serial_data_oe && $past(serial_data_oe) && !(sclk_q && !serial_clock)
    |-> $stable(serial_data))
    else $error("serial bit changed mid-period");
  word_bits_a: assert property ($fell(serial_data_oe) |-> oe_cnt == 5'h10)
    else $error("serial word not sixteen bits");
endmodule

bind sd_decimator sd_decimator_assertions chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .serial_clock(serial_clock), .serial_frame(serial_frame),
  .serial_data(serial_data), .serial_data_oe(serial_data_oe)
);

// [verif/tb_sd_decimator.sv]
// Self-checking bench for the six-channel decimator
`timescale 1ns/10ps
module tb_sd_decimator;
  reg         aclk;
  reg         aresetn;
  reg  [31:0] awaddr;
  reg  [31:0] wdata;
  reg  [31:0] araddr;
  reg  [3:0]  wstrb;
  reg         awvalid;
  reg         wvalid;
  reg         bready;
  reg         arvalid;
  reg         rready;
  reg  [5:0]  modulator_bits;
  wire        awready, wready, bvalid, arready, rvalid;
  wire        ref_high, ref_out, sclk, sframe, sdata, soe, rx_valid, rx_first;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [17:0] gains;
  wire [15:0] rx_word;
  integer     err_total, total_checks, k, n, j, cyc, last_rise, sclk_per, nrx;
  reg  [31:0] seed, rd, exp_gs, code;
  reg  [1:0]  rsp;
  reg  [5:0]  pattern;
  reg         mixed, collect, sclk_q, oe_seen;
  reg  [15:0] exp_q[$];

  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  sd_decimator uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .modulator_bits(modulator_bits), .channel_gain_select(gains),
    .ref_high_range_enable(ref_high), .ref_output_enable(ref_out),
    .serial_clock(sclk), .serial_frame(sframe), .serial_data(sdata), .serial_data_oe(soe)
  );
  host_rx_model host (
    .aclk(aclk), .aresetn(aresetn), .serial_clock(sclk), .serial_frame(sframe), .serial_data(sdata),
    .serial_data_oe(soe), .word(rx_word), .word_valid(rx_valid), .first_of_group(rx_first)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] xorshift(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xorshift = y ^ (y << 5);
    end
  endfunction
  // Constant modulator bit drives the filter to full scale
  function [15:0] coded(input b, input m);
    begin
      if (m)
        coded = b ? 16'h3fff : 16'h4000;
      else
        coded = b ? 16'h7fff : 16'h8000;
    end
  endfunction
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task axi_write(input [31:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    reg bd;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bd = 1'b0;
      while (!bd) begin
        @(posedge aclk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
        bd = bvalid;
        r = bresp;
      end
      bready <= 1'b0;
    end
  endtask
  task axi_read(input [31:0] a, output [31:0] d, output [1:0] r);
    reg done;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (arready)
          arvalid <= 1'b0;
        done = rvalid;
        d = rdata;
        r = rresp;
      end
      rready <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // Link observer and reference model of the word stream
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sclk_q <= sclk;
    if (soe)
      oe_seen <= 1'b1;
    if (sclk && !sclk_q) begin
      sclk_per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (!collect)
      exp_q.delete();
    else if (rx_valid) begin
      if (rx_first) begin
        exp_q.delete();
        for (j = 0; j < 6; j = j + 1)
          exp_q.push_back(coded(pattern[j], mixed));
      end
      if (exp_q.size() > 0) begin
        nrx = nrx + 1;
        check("serial_word", {16'h0, rx_word}, {16'h0, exp_q.pop_front()});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total = err_total + 1;
    finish_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, collect, mixed, oe_seen} = 9'h0;
    {awaddr, wdata, araddr, wstrb, modulator_bits, pattern} = 112'h0;
    {err_total, total_checks, cyc, last_rise, sclk_per, nrx} = {6{32'h0}};
    seed = 32'h8e06989d;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 6; k = k + 1) begin
      axi_read(k * 4, rd, rsp);
      check("reset_reg", rd, 32'h0);
      check("read_resp", {30'h0, rsp}, 32'h0);
    end
    check("reset_pins", {12'h0, ref_high, ref_out, gains}, 32'h0);
    axi_read(32'h1c, rd, rsp);
    check("unmapped_rd", {rd[29:0], rsp}, 32'h2);
    axi_write(32'h38, 32'hffffffff, 4'hf, rsp);
    check("unmapped_wr", {30'h0, rsp}, 32'h2);
    // Every gain code lands on every channel
    for (k = 0; k < 8; k = k + 1) begin
      exp_gs = 32'h0;
      for (n = 0; n < 6; n = n + 1)
        exp_gs[3 * n +: 3] = (k + n) % 8;
      for (n = 0; n < 3; n = n + 1)
        axi_write(32'h0c + 4 * n, {25'h0, exp_gs[6 * n + 3 +: 3], 1'b0, exp_gs[6 * n +: 3]}, 4'h1, rsp);
      check("gain_pins", {14'h0, gains}, exp_gs);
      axi_read(32'h10, rd, rsp);
      check("gain_reg", rd, {25'h0, exp_gs[9 +: 3], 1'b0, exp_gs[6 +: 3]});
    end
    for (k = 0; k < 4; k = k + 1) begin
      axi_write(32'h08, k << 6, 4'h1, rsp);
      check("ref_pins", {30'h0, ref_high, ref_out}, k);
    end
    axi_write(32'h08, 32'h0, 4'h0, rsp);
    check("ref_nostrb", {30'h0, ref_high, ref_out}, 32'h3);
    axi_write(32'h08, 32'h0, 4'h1, rsp);
    // Data mode off: nothing leaves, FIFO fills and overruns
    seed = xorshift(seed);
    pattern <= seed[5:0];
    modulator_bits <= seed[5:0];
    oe_seen <= 1'b0;
    repeat (2000) @(posedge aclk);
    check("idle_link", {31'h0, oe_seen}, 32'h0);
    axi_read(32'h18, rd, rsp);
    check("stall_state", {23'h0, rd[8], 5'h0, rd[2:0]}, 32'h104);
    axi_write(32'h00, 32'h1, 4'h1, rsp);
    repeat (1500) @(posedge aclk);
    collect <= 1'b1;
    repeat (800) @(posedge aclk);
    collect <= 1'b0;
    axi_write(32'h18, 32'h100, 4'h2, rsp);
    axi_read(32'h18, rd, rsp);
    check("overrun_clr", {31'h0, rd[8]}, 32'h0);
    for (n = 0; n < 6; n = n + 1) begin
      axi_read(32'h20 + 4 * n, rd, rsp);
      check("sample_reg", rd, {16'h0, coded(pattern[n], 1'b0)});
    end
    // Mixed mode with a fresh channel pattern
    seed = xorshift(seed);
    pattern <= seed[5:0];
    modulator_bits <= seed[5:0];
    mixed <= 1'b1;
    axi_write(32'h00, 32'h3, 4'h1, rsp);
    repeat (1500) @(posedge aclk);
    collect <= 1'b1;
    repeat (800) @(posedge aclk);
    collect <= 1'b0;
    check("word_count", {31'h0, nrx >= 16}, 32'h1);
    // Divider codes, the last one beyond the top code
    for (k = 0; k < 6; k = k + 1) begin
      code = (k == 5) ? 32'h7 : k;
      axi_write(32'h04, code, 4'h1, rsp);
      repeat (80) @(posedge aclk);
      check("sclk_period", sclk_per, 2 * ((code > 4 ? 4 : code) + 1));
    end
    finish_test;
  end
endmodule
